// ==== inc/pic_pkg.sv ====
package pic_pkg;

	// Command word field positions
	localparam int P_FOURTH_REQ = 0;
	localparam int P_SINGLE = 1;
	localparam int P_INTERVAL = 2;
	localparam int P_LEVEL_TRIG = 3;
	localparam int P_INIT = 4;
	localparam int P_PAGE_LSB = 5;
	localparam int P_VEC_LSB = 3;
	localparam int P_SYS_MODE = 0;
	localparam int P_AUTO_END = 1;
	localparam int P_MASTER_SEL = 2;
	localparam int P_BUFFERED = 3;
	localparam int P_SPEC_NEST = 4;
	localparam int P_ROTATE = 7;
	localparam int P_SET_LEVEL = 6;
	localparam int P_END_INT = 5;
	localparam int P_OPW3 = 3;
	localparam int P_READ_SEL = 0;
	localparam int P_READ_REG = 1;
	localparam int P_POLL = 2;
	localparam int P_SPEC_MASK = 5;
	localparam int P_SPEC_MASK_EN = 6;

	// Reset values and fixed codes
	localparam logic [7:0] RST_MASK = 8'h00;
	localparam logic [7:0] RST_EDGE_PREV = 8'hFF;
	localparam logic [2:0] RST_LOWEST = 3'h7;
	localparam logic [7:0] CALL_OPCODE = 8'hCD;
	localparam logic [1:0] ACKS_CALL = 2'h3;
	localparam logic [1:0] ACKS_VECTOR = 2'h2;

	typedef struct packed {
		logic cs_n;
		logic rd_n;
		logic wr_n;
		logic rsel;
		logic ack_n;
		logic sp;
		logic [2:0] casc;
		logic [7:0] req;
		logic [7:0] din;
	} pic_pins_type;

	localparam pic_pins_type PINS_IDLE = '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1,
		ack_n: 1'b1, default: '0};

	typedef enum logic [1:0] {ST_OPER, ST_W2, ST_W3, ST_W4} pic_state_type;

	typedef struct packed {
		pic_pins_type s1;
		pic_pins_type s2;
		pic_pins_type s3;
		pic_pins_type pv;
		pic_pins_type pq;
		pic_state_type st;
		logic level_trig;
		logic interval4;
		logic single;
		logic fourth_req;
		logic [2:0] page_hi;
		logic [7:0] high_addr;
		logic [7:0] cascade_cfg;
		logic vec_mode;
		logic auto_end;
		logic master_sel;
		logic buffered;
		logic spec_nest;
		logic [7:0] mask;
		logic [7:0] request;
		logic [7:0] in_service;
		logic [7:0] req_prev;
		logic spec_mask;
		logic read_req;
		logic poll;
		logic rot_auto;
		logic [2:0] lowest;
		logic [1:0] ack_cnt;
		logic [2:0] ack_lvl;
		logic ack_slv;
		logic ack_self;
		logic ack_own;
		logic [2:0] casc_out;
		logic [7:0] dout;
		logic doe;
		logic intr;
	} pic_regs_type;

endpackage : pic_pkg

// ==== src/pic_cmd_ctrl.sv ====
// Operation
// - Call entry points spaced 4 apart when interval bit is 1, else 8.
// - Level-trigger bit set bypasses edge detection; requests follow input levels.
// - Call mode uses programmed page bits; low address bits inserted by device.
// - Vector byte takes five programmed high bits plus three level bits.
// - Third init word expected only when single-device flag is 0.
// - Master treats third-word bits as slaves; drives byte 1 in call mode, slave the rest.
// - Slave owns 3-bit identity; answers bytes 2/3 only on cascade match.
// - Fourth init word expected only when requested; five bits used.
// - System-mode bit selects call mode at 0, vector mode at 1.
// - Automatic-end bit clears the in-service bit at the last acknowledge.
// - Buffered mode turns program pin into buffer enable; select bit picks master.
// - Special-nesting bit enables special fully nested operation.
// - Mask word disables inputs per bit; special mask mode masks in-service too.
// - Level bits act only with set-level bit; set priority makes level lowest.
// - Rotate bit with end and set-level bits selects the rotation command.
// - Read select picks in-service or request; read-register bit latches it.
// - Poll bit enters polling; interrupt output held off, read returns poll.
// - Special mask enable gates special mask bit; otherwise mode unchanged.
// - Master serves up to 8 slaves via cascade lines on later acknowledges.
// - Master holds cascade lines low except slave identity during acknowledges.
// - Slaves keep own modes; slave interrupt output feeds a master input.
// - Init word clears mask, edge sense, special mask; lowest 7; request reads.
// - Reads and writes decoded by register select line as documented.
// - Unless slave, first acknowledge sets in-service, clears request, drives call opcode in call mode.
// - Vector byte equals programmed high bits plus requesting input number.
`timescale 1ns/1ps
`default_nettype none
module pic_cmd_ctrl
(
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic cs_n_i,
	input wire logic rd_n_i,
	input wire logic wr_n_i,
	input wire logic register_select_line_i,
	input wire logic [7:0] data_i,
	output logic [7:0] data_o,
	output logic data_oe_o,
	input wire logic [7:0] request_inputs_i,
	input wire logic interrupt_acknowledge_n_i,
	input wire logic [2:0] cascade_lines_i,
	output logic [2:0] cascade_lines_o,
	output logic cascade_lines_oe_o,
	input wire logic slave_program_i,
	output logic slave_program_buffer_enable_n_o,
	output logic slave_program_buffer_enable_oe_o,
	output logic interrupt_o
);
	import pic_pkg::*;

	pic_regs_type r_r;
	pic_regs_type r_nxt;
	pic_pins_type pin_w;
	pic_pins_type agree;
	pic_pins_type p;
	pic_pins_type q;
	logic [7:0] d;
	logic [7:0] rise;
	logic [7:0] req_clr;
	logic [7:0] is_set;
	logic [7:0] is_clr;
	logic [7:0] eff_is;
	logic [3:0] req_v;
	logic [3:0] is_v;
	logic [2:0] lv;
	logic [1:0] cnt;
	logic [1:0] last;
	logic wr_done;
	logic rd_go;
	logic rd_end;
	logic ack_go;
	logic ack_end;
	logic master;
	logic cms;
	logic csl;
	logic okreq;
	logic hit;
	logic self;

	// Highest-priority set bit, searching upward from the lowest level
	function automatic logic [3:0] top_level(input logic [7:0] v, input logic [2:0] low);
		logic [3:0] res;
		logic [2:0] l;
		res = 4'h0;
		for (int i = 8; i >= 1; i--)
		begin
			l = low + 3'(i);
			if (v[l])
				res = {1'b1, l};
		end
		return res;
	endfunction : top_level

	// Priority rank, 0 is highest
	function automatic logic [2:0] rank(input logic [2:0] l, input logic [2:0] low);
		return l - low - 3'h1;
	endfunction : rank

	// Routine address byte for the second acknowledge
	function automatic logic [7:0] low_byte(input pic_regs_type s, input logic [2:0] l);
		if (s.vec_mode)
			return {s.high_addr[7:P_VEC_LSB], l};
		else if (s.interval4)
			return {s.page_hi, l, 2'b00};
		else
			return {s.page_hi[2:1], l, 3'b000};
	endfunction : low_byte

	assign pin_w = '{cs_n: cs_n_i, rd_n: rd_n_i, wr_n: wr_n_i,
		rsel: register_select_line_i, ack_n: interrupt_acknowledge_n_i,
		sp: slave_program_i, casc: cascade_lines_i, req: request_inputs_i,
		din: data_i};

	always_comb
	begin
		r_nxt = r_r;
		r_nxt.s1 = pin_w;
		r_nxt.s2 = r_r.s1;
		r_nxt.s3 = r_r.s2;
		// A pin change counts once stages two and three agree
		agree = r_r.s2 ~^ r_r.s3;
		r_nxt.pv = (agree & r_r.s3) | (~agree & r_r.pv);
		r_nxt.pq = r_r.pv;
		p = r_r.pv;
		q = r_r.pq;
		d = p.din;
		wr_done = !q.wr_n && p.wr_n && !q.cs_n;
		rd_go = q.rd_n && !p.rd_n && !p.cs_n;
		rd_end = !q.rd_n && p.rd_n;
		ack_go = q.ack_n && !p.ack_n;
		ack_end = !q.ack_n && p.ack_n;
		master = r_r.buffered ? r_r.master_sel : p.sp;
		cms = !r_r.single && master;
		csl = !r_r.single && !master;
		last = r_r.vec_mode ? ACKS_VECTOR : ACKS_CALL;
		rise = p.req & ~r_r.req_prev;
		r_nxt.req_prev = p.req;
		req_clr = 8'h00;
		is_set = 8'h00;
		is_clr = 8'h00;
		hit = 1'b0;
		self = 1'b0;
		lv = r_r.ack_lvl;
		cnt = r_r.ack_cnt + 2'h1;

		// Priority resolution against what is in service
		eff_is = r_r.spec_mask ? (r_r.in_service & ~r_r.mask) : r_r.in_service;
		req_v = top_level(r_r.request & ~r_r.mask, r_r.lowest);
		is_v = top_level(eff_is, r_r.lowest);
		okreq = req_v[3] && (!is_v[3]
			|| rank(req_v[2:0], r_r.lowest) < rank(is_v[2:0], r_r.lowest)
			|| (r_r.spec_nest && cms && r_r.cascade_cfg[req_v[2:0]]
			&& req_v[2:0] == is_v[2:0]));
		r_nxt.intr = okreq && !r_r.poll && r_r.st == ST_OPER;

		// Command writes
		if (wr_done)
		begin
			if (!p.rsel && d[P_INIT])
			begin
				r_nxt.st = ST_W2;
				r_nxt.fourth_req = d[P_FOURTH_REQ];
				r_nxt.single = d[P_SINGLE];
				r_nxt.interval4 = d[P_INTERVAL];
				r_nxt.level_trig = d[P_LEVEL_TRIG];
				r_nxt.page_hi = d[7:P_PAGE_LSB];
				r_nxt.mask = RST_MASK;
				r_nxt.req_prev = RST_EDGE_PREV;
				r_nxt.spec_mask = 1'b0;
				r_nxt.lowest = RST_LOWEST;
				r_nxt.read_req = 1'b1;
				r_nxt.poll = 1'b0;
				if (!d[P_FOURTH_REQ])
				begin
					r_nxt.vec_mode = 1'b0;
					r_nxt.auto_end = 1'b0;
					r_nxt.master_sel = 1'b0;
					r_nxt.buffered = 1'b0;
					r_nxt.spec_nest = 1'b0;
				end
			end
			else if (p.rsel)
			begin
				case (r_r.st)
					ST_W2:
					begin
						r_nxt.high_addr = d;
						if (!r_r.single)
							r_nxt.st = ST_W3;
						else if (r_r.fourth_req)
							r_nxt.st = ST_W4;
						else
							r_nxt.st = ST_OPER;
					end
					ST_W3:
					begin
						r_nxt.cascade_cfg = d;
						r_nxt.st = r_r.fourth_req ? ST_W4 : ST_OPER;
					end
					ST_W4:
					begin
						r_nxt.vec_mode = d[P_SYS_MODE];
						r_nxt.auto_end = d[P_AUTO_END];
						r_nxt.master_sel = d[P_MASTER_SEL];
						r_nxt.buffered = d[P_BUFFERED];
						r_nxt.spec_nest = d[P_SPEC_NEST];
						r_nxt.st = ST_OPER;
					end
					ST_OPER:
						r_nxt.mask = d;
					default:
						r_nxt.st = ST_OPER;
				endcase
			end
			else if (r_r.st == ST_OPER && d[P_OPW3])
			begin
				if (d[P_READ_REG])
					r_nxt.read_req = d[P_READ_SEL];
				r_nxt.poll = d[P_POLL];
				if (d[P_SPEC_MASK_EN])
					r_nxt.spec_mask = d[P_SPEC_MASK];
			end
			else if (r_r.st == ST_OPER)
			begin
				case ({d[P_ROTATE], d[P_SET_LEVEL], d[P_END_INT]})
					3'b001:
						is_clr[is_v[2:0]] = is_v[3];
					3'b101:
					begin
						is_clr[is_v[2:0]] = is_v[3];
						if (is_v[3])
							r_nxt.lowest = is_v[2:0];
					end
					3'b011:
						is_clr[d[2:0]] = 1'b1;
					3'b111:
					begin
						is_clr[d[2:0]] = 1'b1;
						r_nxt.lowest = d[2:0];
					end
					3'b110:
						r_nxt.lowest = d[2:0];
					3'b100:
						r_nxt.rot_auto = 1'b1;
					3'b000:
						r_nxt.rot_auto = 1'b0;
					default:
						r_nxt.rot_auto = r_r.rot_auto;
				endcase
			end
		end

		// Register reads
		if (rd_go)
		begin
			r_nxt.doe = 1'b1;
			if (p.rsel)
				r_nxt.dout = r_r.mask;
			else if (r_r.poll)
			begin
				r_nxt.dout = {req_v[3], 4'h0, req_v[2:0]};
				r_nxt.poll = 1'b0;
				if (req_v[3])
				begin
					is_set[req_v[2:0]] = 1'b1;
					req_clr[req_v[2:0]] = 1'b1;
				end
			end
			else
				r_nxt.dout = r_r.read_req ? r_r.request : r_r.in_service;
		end
		if (rd_end)
			r_nxt.doe = 1'b0;

		// Acknowledge sequence
		if (ack_go)
		begin
			r_nxt.ack_cnt = cnt;
			if (cnt == 2'h1)
			begin
				r_nxt.ack_lvl = okreq ? req_v[2:0] : RST_LOWEST;
				r_nxt.ack_slv = cms && okreq && r_r.cascade_cfg[req_v[2:0]];
				r_nxt.ack_own = !csl && okreq;
				if (!csl && okreq)
				begin
					is_set[req_v[2:0]] = 1'b1;
					req_clr[req_v[2:0]] = 1'b1;
				end
				if (!r_r.vec_mode && !csl)
				begin
					r_nxt.dout = CALL_OPCODE;
					r_nxt.doe = 1'b1;
				end
			end
			else if (cnt == 2'h2)
			begin
				if (csl)
				begin
					hit = p.casc == r_r.cascade_cfg[2:0];
					lv = okreq ? req_v[2:0] : RST_LOWEST;
					r_nxt.ack_lvl = lv;
					r_nxt.ack_own = hit && okreq;
					if (hit && okreq)
					begin
						is_set[lv] = 1'b1;
						req_clr[lv] = 1'b1;
					end
				end
				self = csl ? hit : !r_r.ack_slv;
				r_nxt.ack_self = self;
				if (self)
				begin
					r_nxt.dout = low_byte(r_r, lv);
					r_nxt.doe = 1'b1;
				end
			end
			else if (!r_r.vec_mode && r_r.ack_self)
			begin
				r_nxt.dout = r_r.high_addr;
				r_nxt.doe = 1'b1;
			end
		end
		if (ack_end)
		begin
			r_nxt.doe = 1'b0;
			if (r_r.ack_cnt == 2'h1 && r_r.ack_slv)
				r_nxt.casc_out = r_r.ack_lvl;
			if (r_r.ack_cnt == last)
			begin
				r_nxt.ack_cnt = 2'h0;
				r_nxt.casc_out = 3'h0;
				if (r_r.ack_own && r_r.auto_end)
					is_clr[r_r.ack_lvl] = 1'b1;
				if (r_r.ack_own && r_r.auto_end && r_r.rot_auto)
					r_nxt.lowest = r_r.ack_lvl;
			end
		end

		// Set wins over clear on both registers
		r_nxt.in_service = (r_r.in_service & ~is_clr) | is_set;
		if (r_r.level_trig)
			r_nxt.request = p.req;
		else
			r_nxt.request = ((r_r.request & ~req_clr) | rise) & p.req;
	end

	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
		begin
			r_r <= '0;
			r_r.s1 <= PINS_IDLE;
			r_r.s2 <= PINS_IDLE;
			r_r.s3 <= PINS_IDLE;
			r_r.pv <= PINS_IDLE;
			r_r.pq <= PINS_IDLE;
			r_r.st <= ST_OPER;
			r_r.single <= 1'b1;
			r_r.req_prev <= RST_EDGE_PREV;
			r_r.lowest <= RST_LOWEST;
			r_r.read_req <= 1'b1;
		end
		else
			r_r <= r_nxt;
	end

	assign data_o = r_r.dout;
	assign data_oe_o = r_r.doe;
	assign cascade_lines_o = r_r.casc_out;
	assign cascade_lines_oe_o = !r_r.single && (r_r.buffered ? r_r.master_sel : r_r.pv.sp);
	assign slave_program_buffer_enable_n_o = ~r_r.doe;
	assign slave_program_buffer_enable_oe_o = r_r.buffered;
	assign interrupt_o = r_r.intr;

endmodule : pic_cmd_ctrl
`default_nettype wire

// ==== testbench/pic_cmd_ctrl_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
module pic_cmd_ctrl_properties
(
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic rd_n_i,
	input wire logic interrupt_acknowledge_n_i,
	input wire logic data_oe_o,
	input wire logic interrupt_o,
	input wire logic [2:0] cascade_lines_o,
	input wire logic cascade_lines_oe_o,
	input wire logic slave_program_buffer_enable_n_o,
	input wire logic slave_program_buffer_enable_oe_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (sys_rst_i);

	// Strobes idle long enough for any answer to be withdrawn
	sequence strobes_idle;
		(interrupt_acknowledge_n_i && rd_n_i) [*8];
	endsequence
	sequence ack_idle;
		interrupt_acknowledge_n_i [*8];
	endsequence

	a_buf_enable_follows: assert property (
		slave_program_buffer_enable_oe_o |-> slave_program_buffer_enable_n_o == !data_oe_o)
		else $error("buffer enable does not follow data drive");
	a_reset_outputs_quiet: assert property (
		disable iff (1'b0) sys_rst_i |=> !data_oe_o && !interrupt_o && cascade_lines_o == 3'h0)
		else $error("outputs active after reset");
	a_reset_pins_input: assert property (
		disable iff (1'b0) sys_rst_i |=> !cascade_lines_oe_o && !slave_program_buffer_enable_oe_o)
		else $error("pin enables active after reset");
	a_casc_idle_low: assert property (
		ack_idle |-> cascade_lines_o == 3'h0)
		else $error("cascade lines not low outside acknowledge");
	a_bus_released: assert property (
		strobes_idle |-> !data_oe_o)
		else $error("data bus driven without a strobe");
	a_drive_has_cause: assert property (
		$rose(data_oe_o) |-> !$past(rd_n_i, 3) || !$past(interrupt_acknowledge_n_i, 3))
		else $error("data drive started without read or acknowledge");
	a_drive_stands: assert property (
		$fell(data_oe_o) |-> $past(rd_n_i, 3) && $past(interrupt_acknowledge_n_i, 3))
		else $error("data drive dropped while strobe still low");
	a_casc_by_master: assert property (
		cascade_lines_o != 3'h0 |-> cascade_lines_oe_o)
		else $error("slave identity shown while not master");
endmodule : pic_cmd_ctrl_properties

bind pic_cmd_ctrl pic_cmd_ctrl_properties chk (.clk_i, .sys_rst_i, .rd_n_i,
	.interrupt_acknowledge_n_i, .data_oe_o, .interrupt_o, .cascade_lines_o,
	.cascade_lines_oe_o, .slave_program_buffer_enable_n_o, .slave_program_buffer_enable_oe_o);
`default_nettype wire

// ==== testbench/pic_cpu_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module pic_cpu_model
(
	input wire logic clk_i,
	input wire logic data_oe_i,
	output logic cs_n_o,
	output logic rd_n_o,
	output logic wr_n_o,
	output logic sel_o,
	output logic [7:0] data_o,
	output logic ack_n_o
);
	initial
	begin
		cs_n_o = 1'b1;
		rd_n_o = 1'b1;
		wr_n_o = 1'b1;
		sel_o = 1'b0;
		data_o = 8'h5A;
		ack_n_o = 1'b1;
	end

	// Data settles six clocks before the strobe rises; bus inverted once released
	task automatic wr(input logic s, input logic [7:0] d);
		cs_n_o <= 1'b0;
		sel_o <= s;
		data_o <= d;
		wr_n_o <= 1'b0;
		repeat (6) @(posedge clk_i);
		wr_n_o <= 1'b1;
		repeat (6) @(posedge clk_i);
		cs_n_o <= 1'b1;
		data_o <= ~d;
		repeat (2) @(posedge clk_i);
	endtask : wr

	task automatic rd(input logic s);
		cs_n_o <= 1'b0;
		sel_o <= s;
		rd_n_o <= 1'b0;
		for (int n = 0; n < 20 && data_oe_i !== 1'b1; n++)
			@(posedge clk_i);
		rd_n_o <= 1'b1;
		repeat (8) @(posedge clk_i);
		cs_n_o <= 1'b1;
		@(posedge clk_i);
	endtask : rd

	task automatic ack;
		ack_n_o <= 1'b0;
		repeat (6) @(posedge clk_i);
		ack_n_o <= 1'b1;
		repeat (7) @(posedge clk_i);
	endtask : ack
endmodule : pic_cpu_model
`default_nettype wire

// ==== testbench/tb_pic_cmd_ctrl.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_pic_cmd_ctrl;
	logic clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic [7:0] req = 8'h00;
	logic [2:0] casc_in = 3'h0;
	logic sp = 1'b1;
	logic oe_d = 1'b0;
	logic cs_n, rd_n, wr_n, sel, ack_n, doe, casc_oe, ben_n, ben_oe, intr;
	logic [7:0] din, dout, w1, w2, b2;
	logic [2:0] casc_out, lvl;
	logic [7:0] exp_q[$];
	integer seed = 88072;
	int miscompares = 0;
	int comparisons = 0;
	int i;

	always #2.5 clk_i = ~clk_i;

	pic_cpu_model cpu (.clk_i, .data_oe_i(doe), .cs_n_o(cs_n), .rd_n_o(rd_n),
		.wr_n_o(wr_n), .sel_o(sel), .data_o(din), .ack_n_o(ack_n));

	pic_cmd_ctrl uut (.clk_i, .sys_rst_i, .cs_n_i(cs_n), .rd_n_i(rd_n), .wr_n_i(wr_n),
		.register_select_line_i(sel), .data_i(din), .data_o(dout), .data_oe_o(doe),
		.request_inputs_i(req), .interrupt_acknowledge_n_i(ack_n),
		.cascade_lines_i(casc_in), .cascade_lines_o(casc_out), .cascade_lines_oe_o(casc_oe),
		.slave_program_i(sp), .slave_program_buffer_enable_n_o(ben_n),
		.slave_program_buffer_enable_oe_o(ben_oe), .interrupt_o(intr));

	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		comparisons++;
		if (g !== e)
		begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	task automatic stop_test;
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : stop_test

	task automatic rd(input logic s, input logic [7:0] e);
		exp_q.push_back(e);
		cpu.rd(s);
	endtask : rd

	task automatic wint(input logic e);
		for (int n = 0; n < 30 && intr !== e; n++)
			@(posedge clk_i);
		chk("interrupt_o", {7'h0, e}, {7'h0, intr});
	endtask : wint

	// Each new drive of the data bus consumes the oldest expected byte
	always @(posedge clk_i)
	begin
		oe_d <= doe;
		if (doe === 1'b1 && oe_d === 1'b0)
			if (exp_q.size() == 0)
			begin
				comparisons++;
				miscompares++;
				$display("mismatch unexpected_drive expected none seen %h", dout);
			end
			else
				chk("data_o", exp_q.pop_front(), dout);
	end

	initial
	begin
		repeat (20000) @(posedge clk_i);
		miscompares++;
		stop_test();
	end

	initial
	begin
		repeat (10) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		@(posedge clk_i);
		rd(1'b1, 8'h00);
		rd(1'b0, 8'h00);
		for (i = 0; i < 2; i++)
		begin
			w1 = i ? 8'h92 : 8'hB6;
			w2 = i ? 8'h34 : 8'h12;
			lvl = i ? 3'h5 : 3'h3;
			cpu.wr(1'b0, w1);
			cpu.wr(1'b1, w2);
			req <= 8'h01 << lvl;
			wint(1'b1);
			b2 = w1[2] ? {w1[7:5], lvl, 2'h0} : {w1[7:6], lvl, 3'h0};
			exp_q = {exp_q, 8'hCD, b2, w2};
			repeat (3) cpu.ack();
			cpu.wr(1'b0, 8'h0A);
			rd(1'b0, 8'h01 << lvl);
			rd(1'b0, 8'h01 << lvl);
			cpu.wr(1'b0, 8'h20);
			rd(1'b0, 8'h00);
			req <= 8'h00;
		end
		cpu.wr(1'b1, 8'h08);
		rd(1'b1, 8'h08);
		req <= 8'h08;
		repeat (12) @(posedge clk_i);
		wint(1'b0);
		cpu.wr(1'b1, 8'h00);
		wint(1'b1);
		cpu.wr(1'b0, 8'hC2);
		req <= 8'h12;
		cpu.wr(1'b0, 8'h0C);
		wint(1'b0);
		rd(1'b0, 8'h84);
		cpu.wr(1'b0, 8'h20);
		req <= 8'h00;
		cpu.wr(1'b0, 8'hC7);
		req <= 8'h09;
		cpu.wr(1'b0, 8'h0C);
		rd(1'b0, 8'h80);
		cpu.wr(1'b0, 8'h0C);
		rd(1'b0, 8'h83);
		cpu.wr(1'b0, 8'h63);
		rd(1'b0, 8'h01);
		req <= 8'h00;
		cpu.wr(1'b0, 8'hA0);
		rd(1'b0, 8'h00);
		req <= 8'h09;
		cpu.wr(1'b0, 8'h0C);
		rd(1'b0, 8'h83);
		req <= 8'h01;
		cpu.wr(1'b0, 8'hE3);
		rd(1'b0, 8'h00);
		req <= 8'h09;
		cpu.wr(1'b0, 8'h0C);
		rd(1'b0, 8'h80);
		wint(1'b0);
		cpu.wr(1'b1, 8'h01);
		cpu.wr(1'b0, 8'h68);
		wint(1'b1);
		cpu.wr(1'b0, 8'h08);
		wint(1'b1);
		cpu.wr(1'b0, 8'h48);
		wint(1'b0);
		cpu.wr(1'b1, 8'h00);
		req <= 8'h00;
		cpu.wr(1'b0, 8'h20);
		i = $random(seed);
		lvl = i[2:0];
		req <= 8'h01 << lvl;
		cpu.wr(1'b0, 8'h1B);
		cpu.wr(1'b1, 8'hA8);
		cpu.wr(1'b1, 8'h0F);
		wint(1'b1);
		rd(1'b0, 8'h01 << lvl);
		chk("buffer_enable_oe", 8'h01, {7'h0, ben_oe});
		cpu.wr(1'b0, 8'h80);
		exp_q.push_back({5'h15, lvl});
		repeat (2) cpu.ack();
		req <= 8'h00;
		cpu.wr(1'b0, 8'h0A);
		rd(1'b0, 8'h00);
		req <= 8'hFF;
		cpu.wr(1'b0, 8'h0C);
		rd(1'b0, {5'h10, lvl + 3'h1});
		cpu.wr(1'b0, 8'h20);
		req <= 8'h00;
		cpu.wr(1'b0, 8'h14);
		cpu.wr(1'b1, 8'h40);
		cpu.wr(1'b1, 8'h04);
		chk("cascade_oe", 8'h01, {7'h0, casc_oe});
		req <= 8'h04;
		wint(1'b1);
		exp_q.push_back(8'hCD);
		for (i = 0; i < 3; i++)
		begin
			cpu.ack();
			chk("cascade_lines", (i < 2) ? 8'h02 : 8'h00, {5'h0, casc_out});
		end
		cpu.wr(1'b0, 8'h20);
		req <= 8'h02;
		wint(1'b1);
		exp_q = {exp_q, 8'hCD, 8'h04, 8'h40};
		for (i = 0; i < 3; i++)
		begin
			cpu.ack();
			chk("cascade_lines", 8'h00, {5'h0, casc_out});
		end
		cpu.wr(1'b0, 8'h20);
		req <= 8'h00;
		sp <= 1'b0;
		casc_in <= 3'h5;
		cpu.wr(1'b0, 8'h14);
		cpu.wr(1'b1, 8'h60);
		cpu.wr(1'b1, 8'h05);
		req <= 8'h40;
		wint(1'b1);
		exp_q = {exp_q, 8'h18, 8'h60};
		repeat (3) cpu.ack();
		req <= 8'h50;
		casc_in <= 3'h3;
		wint(1'b1);
		repeat (3) cpu.ack();
		repeat (20) @(posedge clk_i);
		chk("pending_bytes", 8'h00, 8'(exp_q.size()));
		stop_test();
	end
endmodule : tb_pic_cmd_ctrl
`default_nettype wire
